// >>> hdl/i2c_flags_pkg.sv
// package for the i2c status flag block: register map, field positions,
// reset values, vector codes and the packed state carriers.
// assumes a 32-bit apb slave with one aligned word per register.
package i2c_flags_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_MODE    = 8'h00;
   localparam logic [7:0] OFS_MASK    = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_VECTOR  = 8'h0C;
   localparam logic [7:0] OFS_RXHOLD  = 8'h10;
   localparam logic [7:0] OFS_BUSSTAT = 8'h14;

   // interrupt_status_reg and mask field positions
   localparam int FLAG_W   = 4;
   localparam int AL_BIT   = 0;
   localparam int NACK_BIT = 1;
   localparam int REG_ACCESS_READY_FLAG_BIT = 2;
   localparam int RRDY_BIT = 3;

   // mode_control_reg field positions
   localparam int RUN_BIT   = 0;
   localparam int MST_BIT   = 1;
   localparam int STP_BIT   = 2;
   localparam int TRX_BIT   = 3;
   localparam int START_BIT = 4;

   // bus status field position
   localparam int BUSY_BIT = 0;

   // int_vector_reg codes
   localparam logic [2:0] VEC_NONE = 3'h0;
   localparam logic [2:0] VEC_AL   = 3'h1;
   localparam logic [2:0] VEC_NACK = 3'h2;
   localparam logic [2:0] VEC_REG_ACCESS_READY_FLAG = 3'h3;
   localparam logic [2:0] VEC_RRDY = 3'h4;

   // index of the last data bit of a word on the bus
   localparam logic [3:0] LAST_BIT = 4'h7;

   // reset values
   localparam logic [3:0] MODE_RST   = 4'h0;
   localparam logic [3:0] MASK_RST   = 4'h0;
   localparam logic [3:0] STATUS_RST = 4'h0;

   typedef struct packed {
      logic trx;
      logic stop_request;
      logic master_select;
      logic module_run_bit;
   } mode_t;

   typedef enum logic [1:0] {
      MON_IDLE = 2'b00,
      MON_DATA = 2'b01,
      MON_ACK  = 2'b10
   } mon_state_t;

   typedef enum logic [2:0] {
      SEL_NONE    = 3'b000,
      SEL_MODE    = 3'b001,
      SEL_MASK    = 3'b010,
      SEL_STATUS  = 3'b011,
      SEL_VECTOR  = 3'b100,
      SEL_RXHOLD  = 3'b101,
      SEL_BUSSTAT = 3'b110
   } reg_sel_t;

   typedef struct packed {
      mode_t       mode;
      logic [3:0]  status;
      logic [3:0]  mask;
      logic [7:0]  rx_shift;
      logic [7:0]  rx_holding;
      logic [3:0]  bit_cnt;
      mon_state_t  mon;
      logic        bus_busy;
      logic        scl_prev;
      logic        sda_prev;
      logic [31:0] prdata;
      logic        pslverr;
      logic [2:0]  vec_lat;
      reg_sel_t    sel_lat;
      logic        start_pulse;
   } state_t;

   localparam state_t STATE_RST = '{
      mode:        mode_t'(MODE_RST),
      status:      STATUS_RST,
      mask:        MASK_RST,
      rx_shift:    8'h00,
      rx_holding:  8'h00,
      bit_cnt:     4'h0,
      mon:         MON_IDLE,
      bus_busy:    1'b0,
      scl_prev:    1'b1,
      sda_prev:    1'b1,
      prdata:      32'h0000_0000,
      pslverr:     1'b0,
      vec_lat:     VEC_NONE,
      sel_lat:     SEL_NONE,
      start_pulse: 1'b0
   };

endpackage

// >>> hdl/pin_sync.sv
// two-flop synchroniser for a group of pin levels.
// assumes the inputs are asynchronous to pclk; only the second stage is read.
module pin_sync #(
   parameter int               WIDTH   = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             pclk,    // module clock
   input  wire logic             presetn, // async reset, active low
   input  wire logic [WIDTH-1:0] async_i, // raw pin levels
   output      logic [WIDTH-1:0] sync_o   // synchronised levels
);

   logic [2*WIDTH-1:0] stage_q;
   logic [2*WIDTH-1:0] stage_d;

   always_comb begin
      stage_d = {stage_q[WIDTH-1:0], async_i};
   end

   // both stages reset to the idle level so no false edge follows reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= {RST_VAL, RST_VAL};
      end else begin
         stage_q <= stage_d;
      end
   end

   assign sync_o = stage_q[2*WIDTH-1:WIDTH];

endmodule

// >>> hdl/i2c_status_flags.sv
// status flag logic of an i2c controller: receive-ready, register-access-ready,
// no-acknowledge and arbitration-lost flags, their mask, vector and mode bits.
// assumes an apb master on pclk, scl/sda pin levels from the bus, and a serial
// engine on pclk that reports when it has consumed the programmed commands.
//
// Chosen here: the register addresses and the APB slave port.
module i2c_status_flags (
   input  wire logic                 pclk,          // module clock, 50 MHz
   input  wire logic                 presetn,       // async reset, active low
   input  wire logic                 psel,          // apb select
   input  wire logic                 penable,       // apb enable
   input  wire logic                 pwrite,        // apb direction, high = write
   input  wire logic [7:0]           paddr,         // apb byte address
   input  wire logic [31:0]          pwdata,        // apb write data
   output      logic [31:0]          prdata,        // apb read data
   output      logic                 pready,        // apb ready
   output      logic                 pslverr,       // apb error, unmapped address
   input  wire logic                 scl_i,         // scl pin level
   input  wire logic                 sda_i,         // sda pin level
   input  wire logic                 tx_bit_release,// engine leaves sda high this bit
   input  wire logic                 general_call,  // engine is in a general call
   input  wire logic                 regs_consumed, // engine used programmed values
   output      i2c_flags_pkg::mode_t mode_o,        // mode bits to the engine
   output      logic                 start_pulse,   // start request to the engine
   output      logic                 bus_busy,      // bus busy indication
   output      logic [3:0]           flag_irq,      // per-flag interrupt requests
   output      logic                 irq            // combined interrupt, active high
);

   i2c_flags_pkg::state_t q;
   i2c_flags_pkg::state_t d;
   logic [1:0]            pins_s;
   logic                  scl_s;
   logic                  sda_s;

   // i2c lines idle high
   pin_sync #(
      .WIDTH   (2),
      .RST_VAL (2'b11)
   ) u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_i ({scl_i, sda_i}),
      .sync_o  (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // address decode shared by the setup and access phases
   function automatic i2c_flags_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
      i2c_flags_pkg::reg_sel_t sel;
      if (addr == i2c_flags_pkg::OFS_MODE) begin
         sel = i2c_flags_pkg::SEL_MODE;
      end else if (addr == i2c_flags_pkg::OFS_MASK) begin
         sel = i2c_flags_pkg::SEL_MASK;
      end else if (addr == i2c_flags_pkg::OFS_STATUS) begin
         sel = i2c_flags_pkg::SEL_STATUS;
      end else if (addr == i2c_flags_pkg::OFS_VECTOR) begin
         sel = i2c_flags_pkg::SEL_VECTOR;
      end else if (addr == i2c_flags_pkg::OFS_RXHOLD) begin
         sel = i2c_flags_pkg::SEL_RXHOLD;
      end else if (addr == i2c_flags_pkg::OFS_BUSSTAT) begin
         sel = i2c_flags_pkg::SEL_BUSSTAT;
      end else begin
         sel = i2c_flags_pkg::SEL_NONE;
      end
      return sel;
   endfunction

   // highest-priority pending unmasked flag; arb-lost first
   function automatic logic [2:0] vec_code(input logic [3:0] pend);
      logic [2:0] code;
      if (pend[i2c_flags_pkg::AL_BIT]) begin
         code = i2c_flags_pkg::VEC_AL;
      end else if (pend[i2c_flags_pkg::NACK_BIT]) begin
         code = i2c_flags_pkg::VEC_NACK;
      end else if (pend[i2c_flags_pkg::REG_ACCESS_READY_FLAG_BIT]) begin
         code = i2c_flags_pkg::VEC_REG_ACCESS_READY_FLAG;
      end else if (pend[i2c_flags_pkg::RRDY_BIT]) begin
         code = i2c_flags_pkg::VEC_RRDY;
      end else begin
         code = i2c_flags_pkg::VEC_NONE;
      end
      return code;
   endfunction

   logic                    scl_rise;
   logic                    start_cond;
   logic                    stop_cond;
   logic                    setup_ph;
   logic                    access_ph;
   logic [3:0]              set_vec;
   logic [3:0]              clr_vec;
   logic [3:0]              pend;
   logic [7:0]              word_in;
   i2c_flags_pkg::reg_sel_t sel_now;

   always_comb begin
      d          = q;
      set_vec    = 4'h0;
      clr_vec    = 4'h0;
      pend       = q.status & q.mask;
      word_in    = {q.rx_shift[6:0], sda_s};
      sel_now    = reg_sel(paddr);
      setup_ph   = psel & ~penable;
      access_ph  = psel & penable;
      scl_rise   = scl_s & ~q.scl_prev;
      start_cond = q.scl_prev & scl_s & q.sda_prev & ~sda_s;
      stop_cond  = q.scl_prev & scl_s & ~q.sda_prev & sda_s;

      d.start_pulse = 1'b0;
      d.scl_prev    = scl_s;
      d.sda_prev    = sda_s;

      // bus monitor: framing, received words and acknowledge slot
      if (start_cond) begin
         d.bus_busy = 1'b1;
         d.mon      = i2c_flags_pkg::MON_DATA;
         d.bit_cnt  = 4'h0;
      end else if (stop_cond) begin
         d.bus_busy = 1'b0;
         d.mon      = i2c_flags_pkg::MON_IDLE;
      end else if (scl_rise) begin
         case (q.mon)
            i2c_flags_pkg::MON_DATA: begin
               d.rx_shift = word_in;
               if (q.mode.master_select && q.mode.trx && tx_bit_release && !sda_s) begin
                  set_vec[i2c_flags_pkg::AL_BIT] = 1'b1;
               end
               if (q.bit_cnt == i2c_flags_pkg::LAST_BIT) begin
                  d.mon = i2c_flags_pkg::MON_ACK;
                  if (!q.mode.trx) begin
                     d.rx_holding = word_in;
                     set_vec[i2c_flags_pkg::RRDY_BIT] = 1'b1;
                  end
               end else begin
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
            end
            i2c_flags_pkg::MON_ACK: begin
               if (q.mode.trx) begin
                  if (sda_s || general_call) begin
                     set_vec[i2c_flags_pkg::NACK_BIT] = 1'b1;
                  end else begin
                     clr_vec[i2c_flags_pkg::NACK_BIT] = 1'b1;
                  end
               end
               d.mon     = i2c_flags_pkg::MON_DATA;
               d.bit_cnt = 4'h0;
            end
            default: begin
               d.mon = i2c_flags_pkg::MON_IDLE;
            end
         endcase
      end

      // engine has used the programmed address, data and command
      if (regs_consumed && q.mode.master_select) begin
         set_vec[i2c_flags_pkg::REG_ACCESS_READY_FLAG_BIT] = 1'b1;
      end

      // apb setup: capture read data, vector and decode for the access phase
      if (setup_ph) begin
         d.sel_lat = sel_now;
         d.vec_lat = vec_code(pend);
         d.pslverr = (sel_now == i2c_flags_pkg::SEL_NONE);
         d.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            case (sel_now)
               i2c_flags_pkg::SEL_MODE:    d.prdata[3:0] = q.mode;
               i2c_flags_pkg::SEL_MASK:    d.prdata[3:0] = q.mask;
               i2c_flags_pkg::SEL_STATUS:  d.prdata[3:0] = q.status;
               i2c_flags_pkg::SEL_VECTOR:  d.prdata[2:0] = vec_code(pend);
               i2c_flags_pkg::SEL_RXHOLD:  d.prdata[7:0] = q.rx_holding;
               i2c_flags_pkg::SEL_BUSSTAT: d.prdata[i2c_flags_pkg::BUSY_BIT] = q.bus_busy;
               default:                    d.prdata = 32'h0000_0000;
            endcase
         end
      end

      // apb access: writes take effect, reads apply their side effects
      if (access_ph && pwrite) begin
         case (q.sel_lat)
            i2c_flags_pkg::SEL_MODE: begin
               d.mode.module_run_bit = pwdata[i2c_flags_pkg::RUN_BIT];
               d.mode.master_select  = pwdata[i2c_flags_pkg::MST_BIT];
               d.mode.stop_request   = pwdata[i2c_flags_pkg::STP_BIT];
               d.mode.trx            = pwdata[i2c_flags_pkg::TRX_BIT];
               if (pwdata[i2c_flags_pkg::START_BIT] && pwdata[i2c_flags_pkg::RUN_BIT]) begin
                  if (q.bus_busy) begin
                     set_vec[i2c_flags_pkg::AL_BIT] = 1'b1;
                  end else begin
                     d.start_pulse = 1'b1;
                     clr_vec[i2c_flags_pkg::REG_ACCESS_READY_FLAG_BIT] = 1'b1;
                  end
               end
            end
            i2c_flags_pkg::SEL_MASK: begin
               d.mask = pwdata[3:0];
            end
            i2c_flags_pkg::SEL_STATUS: begin
               clr_vec = clr_vec | pwdata[3:0];
            end
            default: begin
               d.mask = d.mask;
            end
         endcase
      end else if (access_ph && !pwrite) begin
         if (q.sel_lat == i2c_flags_pkg::SEL_VECTOR) begin
            if (q.vec_lat == i2c_flags_pkg::VEC_NACK) begin
               clr_vec[i2c_flags_pkg::NACK_BIT] = 1'b1;
            end else if (q.vec_lat == i2c_flags_pkg::VEC_AL) begin
               clr_vec[i2c_flags_pkg::AL_BIT] = 1'b1;
            end
         end else if (q.sel_lat == i2c_flags_pkg::SEL_RXHOLD) begin
            clr_vec[i2c_flags_pkg::RRDY_BIT] = 1'b1;
         end
      end

      // flags hold until a clear; a set in the same cycle wins
      d.status = (q.status & ~clr_vec) | set_vec;

      // losing arbitration drops back to slave-receiver
      if (set_vec[i2c_flags_pkg::AL_BIT]) begin
         d.mode.master_select = 1'b0;
         d.mode.stop_request  = 1'b0;
         d.mode.trx           = 1'b0;
         d.start_pulse        = 1'b0;
      end

      // module held in reset keeps every flag clear
      if (!q.mode.module_run_bit) begin
         d.status      = i2c_flags_pkg::STATUS_RST;
         d.start_pulse = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= i2c_flags_pkg::STATE_RST;
      end else begin
         q <= d;
      end
   end

   // access phase always completes in its first cycle
   assign pready      = 1'b1;
   assign prdata      = q.prdata;
   assign pslverr     = q.pslverr;
   assign mode_o      = q.mode;
   assign start_pulse = q.start_pulse;
   assign bus_busy    = q.bus_busy;
   assign flag_irq    = q.status & q.mask;
   assign irq         = |(q.status & q.mask);

endmodule

// >>> dv/i2c_flags_sva.sv
// checker for i2c_status_flags, watching its ports only.
// assumes one pclk domain with presetn async active low.
module i2c_flags_sva (
   input wire logic                 pclk,        // clock
   input wire logic                 presetn,     // reset, low
   input wire logic                 psel,        // apb select
   input wire logic                 penable,     // apb enable
   input wire logic                 pwrite,      // apb write
   input wire logic [7:0]           paddr,       // apb address
   input wire logic [31:0]          pwdata,      // apb data
   input wire logic                 pready,      // apb ready
   input wire logic                 pslverr,     // apb error
   input wire i2c_flags_pkg::mode_t mode_o,      // mode bits
   input wire logic                 start_pulse, // start accepted
   input wire logic                 bus_busy,    // bus busy
   input wire logic [3:0]           flag_irq,    // flag requests
   input wire logic                 irq          // any request
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic mwr = acc && pwrite && paddr == i2c_flags_pkg::OFS_MODE;
   wire logic go  = mwr && pwdata[4] && pwdata[0];
   wire logic [3:0] wmode = pwdata[3:0];
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   a_bad_addr: assert property (acc && paddr > i2c_flags_pkg::OFS_BUSSTAT |-> pslverr)
      else $error("no error on unmapped address");
   a_start_idle: assert property (go && !bus_busy |=> start_pulse)
      else $error("start on idle bus not passed on");
   a_start_busy: assert property (go && bus_busy |=> !start_pulse && !mode_o.master_select)
      else $error("start on busy bus not refused");
   a_start_once: assert property (start_pulse |=> !start_pulse)
      else $error("start pulse longer than one cycle");
   a_mode_write: assert property (mwr && !pwdata[4] |=> mode_o == $past(wmode))
      else $error("mode write not taken");
   a_lost_mode: assert property ($rose(flag_irq[i2c_flags_pkg::AL_BIT]) |->
      !mode_o.master_select && !mode_o.stop_request)
      else $error("master bits kept after arbitration loss");
   a_run_clear: assert property ((!mode_o.module_run_bit) [*2] |-> flag_irq == 4'h0)
      else $error("flag set while held in reset");
   a_irq_any: assert property (irq == |flag_irq)
      else $error("irq differs from flag requests");
   c_lost: cover property ($rose(flag_irq[i2c_flags_pkg::AL_BIT]));
   c_start: cover property (start_pulse);
   c_irq: cover property ($rose(irq));
endmodule

bind i2c_status_flags i2c_flags_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .mode_o, .start_pulse, .bus_busy, .flag_irq, .irq);

// >>> dv/i2c_bus_model.sv
// behavioural model of the other parties on the i2c bus.
// assumes open-drain lines with pull-ups: a released line reads high.
module i2c_bus_model (
   output logic scl_o, // bus clock level
   output logic sda_o  // bus data level
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // scl stands still high between frames; every task is entered on a
   // rising pclk edge and changes lines only between rising edges
   task automatic start_c();
      #10 sda_o = 1'b0;
      #40 scl_o = 1'b0;
      #10;
   endtask
   task automatic put_bit(input logic b);
      #10 sda_o = b;
      #80 scl_o = 1'b1;
      #60 scl_o = 1'b0;
      #10;
   endtask
   // eight data bits msb first, then the ack slot
   task automatic put_byte(input logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      put_bit(ack);
   endtask
   task automatic stop_c();
      #10 sda_o = 1'b0;
      #60 scl_o = 1'b1;
      #40 sda_o = 1'b1;
      #50;
   endtask
endmodule

// >>> dv/test_i2c_status_flags.sv
// self-checking bench for the i2c status flag block.
// assumes the bus model and checker of dv/ and the package of hdl/.
module test_i2c_status_flags;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MD = i2c_flags_pkg::OFS_MODE;
   localparam logic [7:0] MK = i2c_flags_pkg::OFS_MASK;
   localparam logic [7:0] ST = i2c_flags_pkg::OFS_STATUS;
   localparam logic [7:0] VC = i2c_flags_pkg::OFS_VECTOR;
   localparam logic [7:0] RX = i2c_flags_pkg::OFS_RXHOLD;
   localparam logic [7:0] BS = i2c_flags_pkg::OFS_BUSSTAT;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 scl;
   logic                 sda;
   logic                 rel;
   logic                 gcall;
   logic                 used;
   i2c_flags_pkg::mode_t mode;
   logic                 start;
   logic                 busy;
   logic [3:0]           fl_irq;
   logic                 irq;
   logic                 last_err;
   int                   n_errors = 0;
   int                   comparisons = 0;
   int                   cyc = 0;

   i2c_status_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .tx_bit_release(rel),
      .general_call(gcall), .regs_consumed(used), .mode_o(mode), .start_pulse(start),
      .bus_busy(busy), .flag_irq(fl_irq), .irq(irq));
   i2c_bus_model i_bus (.scl_o(scl), .sda_o(sda));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // entered just after a rising edge; one idle cycle follows each transfer
   task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(a, 1'b0, 32'h0000_0000, q);
      chk(q, exp);
   endtask

   task automatic xfer(input logic [7:0] d, input logic ack);
      i_bus.put_byte(d, ack);
      repeat (4) @(posedge pclk);
   endtask

   task automatic consume();
      used <= 1'b1;
      @(posedge pclk);
      used <= 1'b0;
      @(posedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rel = 1'b0;
      gcall = 1'b0;
      used = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ST, 32'h0000_0000);
      rd(VC, 32'h0000_0000);
      rd(MK, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      chk({31'h0, last_err}, 32'h0000_0001);
      $display("test reset done");
      wr(MK, 32'h0000_000F);
      wr(MD, 32'h0000_0001);
      i_bus.start_c();
      xfer(8'hA5, 1'b0);
      rd(BS, 32'h0000_0001);
      chk({31'h0, busy}, 32'h0000_0001);
      rd(ST, 32'h0000_0008);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(VC, {29'h0, i2c_flags_pkg::VEC_RRDY});
      rd(RX, 32'h0000_00A5);
      rd(ST, 32'h0000_0000);
      xfer(8'h3C, 1'b0);
      wr(ST, 32'h0000_0008);
      rd(ST, 32'h0000_0000);
      i_bus.stop_c();
      repeat (6) @(posedge pclk);
      rd(BS, 32'h0000_0000);
      chk({31'h0, busy}, 32'h0000_0000);
      $display("test receive done");
      wr(MD, 32'h0000_000B);
      rel <= 1'b1;
      i_bus.start_c();
      xfer(8'hFF, 1'b1);
      rd(ST, 32'h0000_0002);
      rd(VC, {29'h0, i2c_flags_pkg::VEC_NACK});
      rd(ST, 32'h0000_0000);
      xfer(8'hFF, 1'b1);
      xfer(8'hFF, 1'b0);
      rd(ST, 32'h0000_0000);
      gcall <= 1'b1;
      xfer(8'hFF, 1'b0);
      gcall <= 1'b0;
      wr(ST, 32'h0000_0000);
      rd(ST, 32'h0000_0002);
      wr(ST, 32'h0000_0002);
      rd(ST, 32'h0000_0000);
      $display("test no-ack done");
      // first data bit low while released: lost, then received as slave
      xfer(8'h7F, 1'b1);
      rel <= 1'b0;
      rd(ST, 32'h0000_0009);
      chk({28'h0, mode}, 32'h0000_0001);
      rd(VC, {29'h0, i2c_flags_pkg::VEC_AL});
      rd(RX, 32'h0000_007F);
      rd(ST, 32'h0000_0000);
      wr(MD, 32'h0000_0013);
      rd(ST, 32'h0000_0001);
      chk({28'h0, mode}, 32'h0000_0001);
      wr(ST, 32'h0000_0001);
      rd(ST, 32'h0000_0000);
      i_bus.stop_c();
      repeat (6) @(posedge pclk);
      $display("test arbitration done");
      wr(MD, 32'h0000_0003);
      consume();
      rd(ST, 32'h0000_0004);
      wr(MK, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(MK, 32'h0000_000F);
      wr(MD, 32'h0000_0013);
      rd(ST, 32'h0000_0000);
      consume();
      wr(MD, 32'h0000_0000);
      rd(ST, 32'h0000_0000);
      wr(MD, 32'h0000_0001);
      consume();
      rd(ST, 32'h0000_0000);
      wr(MD, 32'h0000_0003);
      consume();
      rd(ST, 32'h0000_0004);
      // processor reset in mid-run clears a pending flag and the mode bits
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({28'h0, mode}, 32'h0000_0000);
      rd(ST, 32'h0000_0000);
      $display("test access-ready done");
      give_verdict();
   end
endmodule
